//--- shared/fpmm_pkg.sv
`default_nettype none
package fpmm_pkg;
    localparam int unsigned fpmm_width = 32;
    localparam int unsigned fpmm_imm_width = 16;
    localparam int unsigned fpmm_reg_count = 8;
    localparam int unsigned fpmm_idx_width = 3;
    localparam int unsigned fpmm_sign_bit = 31;
    localparam int unsigned fpmm_exp_hi = 30;
    localparam int unsigned fpmm_exp_lo = 23;
    localparam int unsigned fpmm_man_hi = 22;
    localparam logic [31:0] fpmm_reset_value = 32'h00000000;
    localparam logic [31:0] fpmm_pos_inf = 32'h7F800000;
    localparam logic [31:0] fpmm_neg_inf = 32'hFF800000;
    localparam logic [31:0] fpmm_pos_zero = 32'h00000000;
    localparam logic [15:0] fpmm_imm_low = 16'h0000;
    localparam logic [7:0] fpmm_exp_max = 8'hFF;
    localparam logic [7:0] fpmm_exp_min = 8'h00;

    // one-hot operation codes
    typedef enum logic [4:0] {
        fpmm_op_none = 5'h01,
        fpmm_op_max_rr = 5'h02,
        fpmm_op_min_rr = 5'h04,
        fpmm_op_max_imm = 5'h08,
        fpmm_op_min_imm = 5'h10
    } fpmm_op_t;
endpackage
`default_nettype wire

//--- shared/fpmm_cmp_if.sv
`default_nettype none
interface fpmm_cmp_if;
    logic [31:0] a;
    logic [31:0] b;
    logic greater;
    logic less;
    logic equal;
    modport user (output a, output b, input greater, input less, input equal);
    modport core (input a, input b, output greater, output less, output equal);
endinterface
`default_nettype wire

//--- verilog/fpmm_compare.sv
`default_nettype none
module fpmm_compare (
    // operands in, relation out
    fpmm_cmp_if.core cmp
);
    import fpmm_pkg::*;
    wire logic a_neg;
    wire logic b_neg;
    wire logic a_zero;
    wire logic b_zero;
    wire logic both_zero;
    wire logic mag_gt;
    wire logic mag_lt;
    assign a_neg = cmp.a[fpmm_sign_bit];
    assign b_neg = cmp.b[fpmm_sign_bit];
    assign a_zero = (cmp.a[fpmm_exp_hi:0] == 31'h00000000);
    assign b_zero = (cmp.b[fpmm_exp_hi:0] == 31'h00000000);
    assign both_zero = a_zero && b_zero;
    assign mag_gt = cmp.a[fpmm_exp_hi:0] > cmp.b[fpmm_exp_hi:0];
    assign mag_lt = cmp.a[fpmm_exp_hi:0] < cmp.b[fpmm_exp_hi:0];
    // sign-magnitude order; plus and minus zero compare equal
    assign cmp.equal = both_zero || (cmp.a == cmp.b);
    assign cmp.greater = !cmp.equal &&
        ((!a_neg && b_neg) || (!a_neg && !b_neg && mag_gt) ||
         (a_neg && b_neg && mag_lt));
    assign cmp.less = !cmp.equal && !cmp.greater;
endmodule // fpmm_compare
`default_nettype wire

//--- verilog/fpmm_unit.sv
`default_nettype none
module fpmm_unit #(
    parameter int unsigned reg_count = fpmm_pkg::fpmm_reg_count,
    parameter int unsigned idx_width = fpmm_pkg::fpmm_idx_width
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // issue
    input wire logic issue,
    input wire fpmm_pkg::fpmm_op_t op,
    input wire logic with_move,
    input wire logic [idx_width-1:0] first_idx,
    input wire logic [idx_width-1:0] second_idx,
    input wire logic [idx_width-1:0] move_dest_idx,
    input wire logic [idx_width-1:0] move_src_idx,
    input wire logic [15:0] upper_half_immediate,
    // register read port
    input wire logic [idx_width-1:0] read_idx,
    output logic [31:0] read_data,
    // results
    output logic [31:0] result,
    output logic zero_flag,
    output logic negative_flag,
    output logic done
);
    import fpmm_pkg::*;

    logic [31:0] work_reg [reg_count];
    fpmm_cmp_if cmp_bus ();

    fpmm_compare u_cmp (
        .cmp(cmp_bus.core)
    );

    function automatic logic [31:0] fpmm_clean(input logic [31:0] v);
        logic [7:0] e;
        e = v[fpmm_exp_hi:fpmm_exp_lo];
        if (e == fpmm_exp_max && v[fpmm_man_hi:0] != 23'h000000) begin
            fpmm_clean = v[fpmm_sign_bit] ? fpmm_neg_inf : fpmm_pos_inf;
        end else if (e == fpmm_exp_min) begin
            fpmm_clean = fpmm_pos_zero;
        end else begin
            fpmm_clean = v;
        end
    endfunction

    wire logic [31:0] first_val;
    wire logic [31:0] second_val;
    wire logic [31:0] imm_val;
    wire logic [31:0] other_val;
    wire logic is_imm;
    wire logic is_max;
    wire logic active;
    wire logic take_other;
    wire logic do_move;
    wire logic [31:0] next_first;

    assign active = issue && (is_imm || op == fpmm_op_max_rr ||
        op == fpmm_op_min_rr);
    assign is_imm = (op == fpmm_op_max_imm) || (op == fpmm_op_min_imm);
    assign is_max = (op == fpmm_op_max_imm) || (op == fpmm_op_max_rr);
    assign first_val = work_reg[first_idx];
    assign second_val = work_reg[second_idx];
    assign imm_val = {upper_half_immediate, fpmm_imm_low};
    assign other_val = is_imm ? imm_val : second_val;
    assign cmp_bus.a = first_val;
    assign cmp_bus.b = other_val;
    // max loads when first less; min loads when first greater
    assign take_other = is_max ? cmp_bus.less : cmp_bus.greater;
    assign do_move = active && !is_imm && with_move && take_other;
    assign next_first = fpmm_clean(take_other ? other_val : first_val);
    assign read_data = work_reg[read_idx];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < reg_count; i++) begin
                work_reg[i] <= fpmm_reset_value;
            end
        end else if (active) begin
            work_reg[first_idx] <= next_first;
            if (do_move) begin
                work_reg[move_dest_idx] <= work_reg[move_src_idx];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zero_flag <= 1'b0;
            negative_flag <= 1'b0;
            result <= fpmm_reset_value;
            done <= 1'b0;
        end else begin
            done <= active;
            if (active) begin
                zero_flag <= cmp_bus.equal;
                negative_flag <= cmp_bus.less;
                result <= next_first;
            end
        end
    end

    chk_max_imm_load: assert property (@(posedge clk) disable iff (rst)
        (active && op == fpmm_op_max_imm && cmp_bus.less) |=>
        result == fpmm_clean($past(imm_val)))
        else $error("max immediate did not load constant");

    chk_max_imm_keep: assert property (@(posedge clk) disable iff (rst)
        (active && op == fpmm_op_max_imm && !cmp_bus.less) |=>
        result == fpmm_clean($past(first_val)))
        else $error("max immediate changed register");

    chk_min_imm_load: assert property (@(posedge clk) disable iff (rst)
        (active && op == fpmm_op_min_imm && cmp_bus.greater) |=>
        result == fpmm_clean($past(imm_val)))
        else $error("min immediate did not load constant");

    chk_min_imm_keep: assert property (@(posedge clk) disable iff (rst)
        (active && op == fpmm_op_min_imm && !cmp_bus.greater) |=>
        result == fpmm_clean($past(first_val)))
        else $error("min immediate changed register");

    chk_imm_low_zero: assert property (@(posedge clk) disable iff (rst)
        (active && is_imm && cmp_bus.b[15:0] != 16'h0000) |-> 1'b0)
        else $error("immediate low half not zero");

    chk_imm_upper: assert property (@(posedge clk) disable iff (rst)
        (active && is_imm) |-> cmp_bus.b[fpmm_sign_bit:fpmm_imm_width] ==
        upper_half_immediate)
        else $error("immediate upper half misplaced");

    chk_no_nan_out: assert property (@(posedge clk) disable iff (rst)
        done |-> !(result[fpmm_exp_hi:fpmm_exp_lo] == fpmm_exp_max &&
        result[fpmm_man_hi:0] != 23'h000000) &&
        (result[fpmm_exp_hi:fpmm_exp_lo] != fpmm_exp_min ||
        result == fpmm_pos_zero))
        else $error("nan or denormal result stored");

    chk_nan_to_inf: assert property (@(posedge clk) disable iff (rst)
        (active && take_other && other_val[fpmm_exp_hi:fpmm_exp_lo] ==
        fpmm_exp_max && other_val[fpmm_man_hi:0] != 23'h000000) |=>
        result[fpmm_exp_hi:0] == fpmm_pos_inf[fpmm_exp_hi:0] &&
        result[fpmm_sign_bit] == $past(other_val[fpmm_sign_bit]))
        else $error("nan result not turned into infinity");

    chk_denorm_zero: assert property (@(posedge clk) disable iff (rst)
        (active && take_other &&
        other_val[fpmm_exp_hi:fpmm_exp_lo] == fpmm_exp_min) |=>
        result == fpmm_pos_zero)
        else $error("denormal result not turned into zero");

    chk_flag_relation: assert property (@(posedge clk) disable iff (rst)
        active |=> (zero_flag == $past(cmp_bus.equal)) &&
        (negative_flag == $past(cmp_bus.less)) && !(zero_flag && negative_flag))
        else $error("flags do not match comparison");

    chk_flags_hold: assert property (@(posedge clk) disable iff (rst)
        !active |=> $stable(zero_flag) && $stable(negative_flag))
        else $error("flags changed without operation");

    chk_min_rr_load: assert property (@(posedge clk) disable iff (rst)
        (active && op == fpmm_op_min_rr && cmp_bus.greater) |=>
        result == fpmm_clean($past(second_val)))
        else $error("register minimum did not load second");

    chk_min_rr_keep: assert property (@(posedge clk) disable iff (rst)
        (active && op == fpmm_op_min_rr && !cmp_bus.greater) |=>
        result == fpmm_clean($past(first_val)))
        else $error("register minimum changed first");

    chk_max_rr_load: assert property (@(posedge clk) disable iff (rst)
        (active && op == fpmm_op_max_rr && cmp_bus.less) |=>
        result == fpmm_clean($past(second_val)))
        else $error("register maximum did not load second");

    chk_max_rr_keep: assert property (@(posedge clk) disable iff (rst)
        (active && op == fpmm_op_max_rr && !cmp_bus.less) |=>
        result == fpmm_clean($past(first_val)))
        else $error("register maximum changed first");

    chk_move_guard: assert property (@(posedge clk) disable iff (rst)
        do_move |-> !is_imm && ((is_max && cmp_bus.less) ||
        (!is_max && cmp_bus.greater)))
        else $error("parallel move without condition");

    chk_imm_no_move: assert property (@(posedge clk) disable iff (rst)
        (active && is_imm && move_dest_idx != first_idx) |=>
        work_reg[$past(move_dest_idx)] == $past(work_reg[move_dest_idx]))
        else $error("immediate form performed a move");

    chk_move_copy: assert property (@(posedge clk) disable iff (rst)
        (do_move && move_dest_idx != first_idx) |=>
        work_reg[$past(move_dest_idx)] == $past(work_reg[move_src_idx]))
        else $error("parallel move value wrong");

    chk_move_skip: assert property (@(posedge clk) disable iff (rst)
        (active && !is_imm && with_move && !take_other &&
        move_dest_idx != first_idx) |=>
        work_reg[$past(move_dest_idx)] == $past(work_reg[move_dest_idx]))
        else $error("parallel move without condition changed register");

    chk_single_cycle: assert property (@(posedge clk) disable iff (rst)
        active |=> done ##1 (done == $past(active)))
        else $error("operation not done in one cycle");

    chk_done_idle: assert property (@(posedge clk) disable iff (rst)
        !active |=> !done)
        else $error("done without operation");

    chk_reg_update: assert property (@(posedge clk) disable iff (rst)
        (active && !(do_move && move_dest_idx == first_idx)) |=>
        work_reg[$past(first_idx)] == result)
        else $error("register not written in one cycle");

    chk_result_hold: assert property (@(posedge clk) disable iff (rst)
        !active |=> $stable(result))
        else $error("result changed without operation");
endmodule // fpmm_unit
`default_nettype wire

//--- tb/fpmm_issue_model.sv
`default_nettype none
module fpmm_issue_model (
    // clock
    input wire logic clk,
    // issue fields
    output logic issue,
    output var fpmm_pkg::fpmm_op_t op,
    output logic with_move,
    output logic [2:0] first_idx,
    output logic [2:0] second_idx,
    output logic [2:0] move_dest_idx,
    output logic [2:0] move_src_idx,
    output logic [15:0] upper_half_immediate
);
    timeunit 1ns;
    timeprecision 100ps;
    import fpmm_pkg::*;
    initial begin
        issue = 1'b0;
        op = fpmm_op_none;
        {with_move, first_idx, second_idx} = 7'h00;
        {move_dest_idx, move_src_idx} = 6'h00;
        upper_half_immediate = 16'h0000;
    end
    // one issue cycle, then issue and op go idle with a changed immediate
    task send(input fpmm_op_t o, input logic m, input logic [2:0] f,
              input logic [2:0] s, input logic [2:0] d,
              input logic [2:0] r, input logic [15:0] k);
        @(posedge clk);
        issue <= 1'b1;
        op <= o;
        with_move <= m;
        {first_idx, second_idx, move_dest_idx, move_src_idx} <= {f, s, d, r};
        upper_half_immediate <= k;
        @(posedge clk);
        issue <= 1'b0;
        op <= fpmm_op_none;
        upper_half_immediate <= ~k;
    endtask
    // two immediate ops on consecutive edges, the second reads the first
    task send_two(input fpmm_op_t o1, input fpmm_op_t o2,
                  input logic [2:0] f, input logic [15:0] k1,
                  input logic [15:0] k2);
        @(posedge clk);
        issue <= 1'b1;
        op <= o1;
        with_move <= 1'b0;
        first_idx <= f;
        upper_half_immediate <= k1;
        @(posedge clk);
        op <= o2;
        upper_half_immediate <= k2;
        @(posedge clk);
        issue <= 1'b0;
        op <= fpmm_op_none;
        upper_half_immediate <= ~k2;
    endtask
endmodule // fpmm_issue_model
`default_nettype wire

//--- tb/fpmm_unit_test.sv
`default_nettype none
module fpmm_unit_test;
    timeunit 1ns;
    timeprecision 100ps;
    import fpmm_pkg::*;
    localparam fpmm_op_t mxi = fpmm_op_max_imm;
    localparam fpmm_op_t mni = fpmm_op_min_imm;
    localparam fpmm_op_t mxr = fpmm_op_max_rr;
    localparam fpmm_op_t mnr = fpmm_op_min_rr;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] read_idx = 3'h0;
    logic issue, with_move, zero_flag, negative_flag, done;
    fpmm_op_t op;
    logic [2:0] first_idx, second_idx, move_dest_idx, move_src_idx;
    logic [15:0] upper_half_immediate;
    logic [31:0] read_data, result;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    fpmm_issue_model i_model (.clk(clk), .issue(issue), .op(op),
        .with_move(with_move), .first_idx(first_idx),
        .second_idx(second_idx), .move_dest_idx(move_dest_idx),
        .move_src_idx(move_src_idx),
        .upper_half_immediate(upper_half_immediate));
    fpmm_unit i_dut (.clk(clk), .rst(rst), .issue(issue), .op(op),
        .with_move(with_move), .first_idx(first_idx),
        .second_idx(second_idx), .move_dest_idx(move_dest_idx),
        .move_src_idx(move_src_idx),
        .upper_half_immediate(upper_half_immediate),
        .read_idx(read_idx), .read_data(read_data), .result(result),
        .zero_flag(zero_flag), .negative_flag(negative_flag), .done(done));
    always #12.5 clk = ~clk;
    task check(string name, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task end_sim;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            end_sim;
        end
    end
    // issue, then judge done, result and flags one cycle later
    task op_chk(fpmm_op_t o, logic m, logic [2:0] f, logic [2:0] s,
                logic [2:0] d, logic [2:0] r, logic [15:0] k,
                logic [31:0] res, logic [1:0] zn);
        i_model.send(o, m, f, s, d, r, k);
        #1;
        check("done", {31'h0, done}, 32'h1);
        check("result", result, res);
        check("flags", {30'h0, zero_flag, negative_flag}, {30'h0, zn});
        @(posedge clk);
        #1;
        check("done_pulse", {31'h0, done}, 32'h0);
    endtask
    task reg_is(logic [2:0] i, logic [31:0] v);
        @(posedge clk);
        read_idx <= i;
        #1;
        check("reg", read_data, v);
    endtask
    task t_imm;
        op_chk(mxi,0,0,0,0,0,16'h4000,32'h40000000,2'b01);
        op_chk(mxi,1,0,0,0,0,16'h3F00,32'h40000000,2'b00);
        op_chk(mni,0,1,0,0,0,16'hBFC0,32'hBFC00000,2'b00);
        op_chk(mni,0,1,0,0,0,16'hBFC0,32'hBFC00000,2'b10);
        reg_is(1, 32'hBFC00000);
    endtask
    task t_rr;
        op_chk(mnr,0,0,1,0,0,16'h0000,32'hBFC00000,2'b00);
        op_chk(mnr,0,0,1,0,0,16'h0000,32'hBFC00000,2'b10);
        op_chk(mxi,0,2,0,0,0,16'h4080,32'h40800000,2'b01);
        op_chk(mxi,0,3,0,0,0,16'h40A0,32'h40A00000,2'b01);
    endtask
    task t_move;
        op_chk(mxr,1,1,2,4,3,16'h0000,32'h40800000,2'b01);
        reg_is(4, 32'h40A00000);
        op_chk(mxr,1,3,0,5,2,16'h0000,32'h40A00000,2'b00);
        reg_is(5, 32'h00000000);
        op_chk(mnr,1,3,2,6,0,16'h0000,32'h40800000,2'b00);
        reg_is(6, 32'hBFC00000);
        op_chk(mnr,1,2,3,7,0,16'h0000,32'h40800000,2'b10);
        reg_is(7, 32'h00000000);
    endtask
    task t_clean;
        op_chk(mxi,0,5,0,0,0,16'h7FC0,32'h7F800000,2'b01);
        op_chk(mxi,0,7,0,0,0,16'h0040,32'h00000000,2'b01);
        op_chk(mni,0,6,0,0,0,16'hFFC0,32'hFF800000,2'b00);
        op_chk(mxi,0,7,0,0,0,16'h8000,32'h00000000,2'b10);
        reg_is(5, 32'h7F800000);
    endtask
    // op none with issue high changes nothing
    task t_refuse;
        i_model.send(fpmm_op_none, 1'b0, 3'h0, 3'h1, 3'h0, 3'h0, 16'h4000);
        #1;
        check("idle_done", {31'h0, done}, 32'h0);
        check("idle_result", result, 32'h00000000);
        check("idle_flags", {30'h0, zero_flag, negative_flag}, 32'h2);
        reg_is(0, 32'hBFC00000);
    endtask
    // dependent op on the next edge sees the first op's result
    task t_order;
        i_model.send_two(mxi, mni, 3'h0, 16'h4000, 16'h3F80);
        #1;
        check("b2b_done", {31'h0, done}, 32'h1);
        check("b2b_result", result, 32'h3F800000);
        check("b2b_flags", {30'h0, zero_flag, negative_flag}, 32'h0);
        @(posedge clk);
        #1;
        check("b2b_pulse", {31'h0, done}, 32'h0);
        reg_is(0, 32'h3F800000);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_imm;
        t_rr;
        t_move;
        t_clean;
        t_refuse;
        t_order;
        end_sim;
    end
endmodule // fpmm_unit_test
`default_nettype wire
